// >>> hdl/rag_guard.sv
// Region access guard: protection check and code/system port steering
// Functional notes
// [R1] Code-region accesses go to code port
// [R2] Addresses from system base go to system port
// [R3] Eight regions, eight subregions each
// [R4] Uncovered or forbidden access faults
// [R5] Read-only region refuses writes
// [R6] No-access region refuses everything
// [R7] Refused access reaches no bus port
`timescale 1ns/1ns
`default_nettype none
module rag_guard
    import rag_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Protection setup
    input wire logic prot_enable,
    input wire logic [RAG_NUM_RGN-1:0] rgn_enable,
    input wire logic [RAG_NUM_RGN-1:0][RAG_ADDR_W-1:0] rgn_base,
    input wire logic [RAG_NUM_RGN-1:0][RAG_EXP_W-1:0] rgn_size_exp,
    input wire logic [RAG_NUM_RGN-1:0][RAG_NUM_SUB-1:0] rgn_sub_disable,
    input wire logic [RAG_NUM_RGN-1:0] rgn_read_only,
    input wire logic [RAG_NUM_RGN-1:0] rgn_no_access,
    // Access from the core
    input wire logic req_valid,
    input wire logic [RAG_ADDR_W-1:0] req_addr,
    input wire logic req_write,
    input wire logic req_instr,
    // Forwarded access
    output logic code_valid,
    output logic sys_valid,
    output logic [RAG_ADDR_W-1:0] fwd_addr,
    output logic fwd_write,
    output logic fwd_instr,
    // Fault toward the core
    output logic fault,
    output logic [RAG_ADDR_W-1:0] fault_addr
);
    logic [RAG_NUM_RGN-1:0] hit_vec;
    logic hit_any;
    logic sel_ro;
    logic sel_na;
    logic allowed;
    logic to_sys;
    logic code_valid_q, code_valid_d;
    logic sys_valid_q, sys_valid_d;
    rag_addr_t fwd_addr_q, fwd_addr_d;
    logic fwd_write_q, fwd_write_d;
    logic fwd_instr_q, fwd_instr_d;
    logic fault_q, fault_d;
    rag_addr_t fault_addr_q, fault_addr_d;

    // [R3] one matcher per region
    for (genvar g = 0; g < RAG_NUM_RGN; g++) begin : g_rgn
        rag_rgn_if rif ();
        assign rif.addr = req_addr;
        assign rif.base = rgn_base[g];
        assign rif.size_exp = rgn_size_exp[g];
        assign rif.enable = rgn_enable[g];
        assign rif.sub_disable = rgn_sub_disable[g];
        assign hit_vec[g] = rif.hit;
        rag_rgn_match u_match (
            .rgn(rif)
        );
    end

    // Overlaps resolve to the highest-numbered region
    always_comb begin
        hit_any = 1'b0;
        sel_ro = 1'b0;
        sel_na = 1'b0;
        for (int i = 0; i < RAG_NUM_RGN; i++) begin
            if (hit_vec[i]) begin
                hit_any = 1'b1;
                sel_ro = rgn_read_only[i];
                sel_na = rgn_no_access[i];
            end
        end
    end

    // Permission and port choice for the current access
    always_comb begin
        // [R4] uncovered or forbidden refused
        allowed = !prot_enable || (hit_any
            // [R6] no-access region blocks all
            && !sel_na
            // [R5] read-only blocks writes
            && !(sel_ro && req_write));
        // [R2] system base and above
        to_sys = (req_addr >= RAG_SYS_BASE);
    end

    // Next values of the forwarded access and the fault
    always_comb begin
        // [R1] code region steering
        code_valid_d = req_valid && allowed && !to_sys;
        // [R2] system region steering
        sys_valid_d = req_valid && allowed && to_sys;
        // Hold address when idle so the ports stay quiet
        fwd_addr_d = fwd_addr_q;
        fwd_write_d = fwd_write_q;
        fwd_instr_d = fwd_instr_q;
        // [R7] refused access never forwarded
        if (req_valid && allowed) begin
            fwd_addr_d = req_addr;
            fwd_write_d = req_write;
            fwd_instr_d = req_instr;
        end
        // [R4] one-cycle fault pulse
        fault_d = req_valid && !allowed;
        fault_addr_d = fault_addr_q;
        if (fault_d) begin
            fault_addr_d = req_addr;
        end
    end

    // Register every output
    always_ff @(posedge clock) begin
        if (reset) begin
            code_valid_q <= 1'b0;
            sys_valid_q <= 1'b0;
            fwd_addr_q <= RAG_ADDR_RST;
            fwd_write_q <= 1'b0;
            fwd_instr_q <= 1'b0;
            fault_q <= 1'b0;
            fault_addr_q <= RAG_ADDR_RST;
        end else begin
            code_valid_q <= code_valid_d;
            sys_valid_q <= sys_valid_d;
            fwd_addr_q <= fwd_addr_d;
            fwd_write_q <= fwd_write_d;
            fwd_instr_q <= fwd_instr_d;
            fault_q <= fault_d;
            fault_addr_q <= fault_addr_d;
        end
    end

    assign code_valid = code_valid_q;
    assign sys_valid = sys_valid_q;
    assign fwd_addr = fwd_addr_q;
    assign fwd_write = fwd_write_q;
    assign fwd_instr = fwd_instr_q;
    assign fault = fault_q;
    assign fault_addr = fault_addr_q;

    // Checks on routing and refusal
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_code_route: assert property ( // [R1]
        (req_valid && !prot_enable && req_addr < RAG_SYS_BASE)
        |=> code_valid_q && !sys_valid_q && fwd_addr_q == $past(req_addr))
        else $error("code access not on code port");
    a_sys_route: assert property ( // [R2]
        sys_valid_q |-> fwd_addr_q >= RAG_SYS_BASE && !code_valid_q)
        else $error("system port got a code address");
    a_miss_fault: assert property ( // [R4]
        (req_valid && prot_enable && !hit_any) |=> fault_q
        && fault_addr_q == $past(req_addr))
        else $error("uncovered access did not fault");
    a_ro_write: assert property ( // [R5]
        (req_valid && prot_enable && hit_any && sel_ro && req_write)
        |=> fault_q)
        else $error("write to read-only region passed");
    a_ro_read: assert property ( // [R5]
        (req_valid && prot_enable && hit_any && !sel_na && !req_write)
        |=> (code_valid_q || sys_valid_q) && !fault_q)
        else $error("permitted read was refused");
    a_no_access: assert property ( // [R6]
        (req_valid && prot_enable && hit_any && sel_na) |=> fault_q)
        else $error("no-access region passed an access");
    a_fault_block: assert property ( // [R7]
        fault_q |-> !code_valid_q && !sys_valid_q)
        else $error("refused access was forwarded");
    a_sub_hole: assert property ( // [R3]
        (req_valid && prot_enable && hit_vec == '0)
        |=> fault_q && !code_valid_q)
        else $error("access with no region hit passed");

    // [R4] each request answered exactly once
    a_one_answer: assert property ( // [R4]
        req_valid |=> $onehot({code_valid_q, sys_valid_q, fault_q}))
        else $error("access got no answer or two answers");
    // [R7] no pulse without a request
    a_no_spurious: assert property ( // [R7]
        !req_valid |=> !code_valid_q && !sys_valid_q && !fault_q)
        else $error("port pulse without a request");
    // [R4] protection off never faults
    a_pass_all: assert property ( // [R4]
        (req_valid && !prot_enable) |=> !fault_q)
        else $error("access faulted with protection off");
    // [R7] refused access leaves forwarded fields
    a_fwd_hold: assert property ( // [R7]
        fault_q |-> $stable(fwd_addr_q) && $stable(fwd_write_q)
        && $stable(fwd_instr_q))
        else $error("refused access changed forwarded fields");
    // [R4] fault address held between faults, reset aside
    a_fault_hold: assert property ( // [R4]
        (!fault_q && !$past(reset)) |-> $stable(fault_addr_q))
        else $error("fault address moved without a fault");

    // [R3] disabled region or subregions never hit
    for (genvar h = 0; h < RAG_NUM_RGN; h++) begin : g_chk
        a_rgn_off: assert property ( // [R3]
            (!rgn_enable[h] || rgn_sub_disable[h] == '1) |-> !hit_vec[h])
            else $error("disabled region reported a hit");
    end

    c_code_pass: cover property (code_valid_q && fwd_instr_q);
    c_sys_pass: cover property (sys_valid_q && fwd_write_q);
    c_ro_fault: cover property (req_valid && prot_enable && sel_ro
        && req_write ##1 fault_q);
    c_miss_fault: cover property (req_valid && prot_enable && !hit_any
        ##1 fault_q);
    // Pass-all mode still steers to a port
    c_pass_all: cover property (req_valid && !prot_enable ##1 code_valid_q);
endmodule : rag_guard
`default_nettype wire

// >>> hdl/rag_pkg.sv
// Shared constants and types for the region access guard
package rag_pkg;
    // Bus and address geometry
    localparam int RAG_ADDR_W = 32;
    localparam int RAG_NUM_RGN = 8;
    localparam int RAG_NUM_SUB = 8;
    localparam int RAG_SUB_W = 3;
    localparam int RAG_EXP_W = 6;
    // Code region starts at zero, system region above it
    localparam logic [31:0] RAG_CODE_BASE = 32'h0000_0000;
    localparam logic [31:0] RAG_SYS_BASE = 32'h2000_0000;
    // Region size is two to the power of the exponent, in bytes
    localparam logic [5:0] RAG_MIN_EXP = 6'h08;
    localparam logic [5:0] RAG_MAX_EXP = 6'h20;
    localparam logic [5:0] RAG_SUB_SHIFT = 6'h03;
    // Reset values of the forwarded access
    localparam logic [31:0] RAG_ADDR_RST = 32'h0000_0000;
    typedef logic [RAG_ADDR_W-1:0] rag_addr_t;
endpackage : rag_pkg

// >>> hdl/rag_rgn_if.sv
// Carrier between the guard and one region matcher
`timescale 1ns/1ns
`default_nettype none
interface rag_rgn_if;
    import rag_pkg::*;
    rag_addr_t addr;
    rag_addr_t base;
    logic [RAG_EXP_W-1:0] size_exp;
    logic enable;
    logic [RAG_NUM_SUB-1:0] sub_disable;
    logic hit;
    // Guard side drives the setup and the address
    modport owner (output addr, base, size_exp, enable, sub_disable,
        input hit);
    // Matcher side answers with the hit
    modport matcher (input addr, base, size_exp, enable, sub_disable,
        output hit);
endinterface : rag_rgn_if
`default_nettype wire

// >>> hdl/rag_rgn_match.sv
// One protection region: address compare and subregion masking
`timescale 1ns/1ns
`default_nettype none
module rag_rgn_match
    import rag_pkg::*;
(
    // Region setup and answer
    rag_rgn_if.matcher rgn
);
    logic [RAG_EXP_W-1:0] exp_eff;
    logic [32:0] size_mask;
    logic in_range;
    logic [RAG_SUB_W-1:0] sub_idx;

    // Clamp size, compare upper bits, pick the subregion
    always_comb begin
        exp_eff = rgn.size_exp;
        if (exp_eff < RAG_MIN_EXP) begin
            exp_eff = RAG_MIN_EXP; // Too small to split in eight
        end else if (exp_eff > RAG_MAX_EXP) begin
            exp_eff = RAG_MAX_EXP;
        end
        size_mask = ~((33'h1 << exp_eff) - 33'h1);
        in_range = ((({1'b0, rgn.addr} ^ {1'b0, rgn.base}) & size_mask)
            == 33'h0);
        sub_idx = RAG_SUB_W'(rgn.addr >> (exp_eff - RAG_SUB_SHIFT));
        // [R3] disabled subregion uncovers
        rgn.hit = rgn.enable && in_range && !rgn.sub_disable[sub_idx];
    end
endmodule : rag_rgn_match
`default_nettype wire

// >>> verif/rag_core_model.sv
// Core-side model that issues one access per bench command
`timescale 1ns/1ns
`default_nettype none
module rag_core_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Command from the bench
    input wire logic go,
    input wire logic [31:0] cmd_addr,
    input wire logic cmd_write,
    input wire logic cmd_instr,
    // Access toward the guard
    output logic req_valid,
    output logic [31:0] req_addr,
    output logic req_write,
    output logic req_instr
);
    // Idle lines toggle so a stale value never looks like a request
    always_ff @(posedge clock) begin
        req_valid <= go & ~reset;
        req_addr <= reset ? 32'h0 : (go ? cmd_addr : ~req_addr);
        req_write <= reset ? 1'b0 : (go ? cmd_write : ~req_write);
        req_instr <= reset ? 1'b0 : (go ? cmd_instr : ~req_instr);
    end
endmodule : rag_core_model
`default_nettype wire

// >>> verif/test_region_access_guard.sv
// Self-checking bench for the region access guard
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_region_access_guard;
    import rag_pkg::*;
    typedef struct {logic [31:0] a; logic w; logic [1:0] e;} rag_row_t;
    logic clock = 1'b0, reset = 1'b1, prot_enable = 1'b1, go = 1'b0;
    logic [7:0] rgn_enable = 8'h9f, rgn_read_only = 8'h02;
    logic [7:0] rgn_no_access = 8'h14;
    logic [7:0][31:0] rgn_base = '0;
    logic [7:0][5:0] rgn_size_exp = '0;
    logic [7:0][7:0] rgn_sub_disable = '0;
    logic req_valid, req_write, req_instr, cmd_write = 1'b0, cmd_instr = 1'b0;
    logic [31:0] req_addr, fwd_addr, fault_addr, cmd_addr = 32'h0;
    logic code_valid, sys_valid, fwd_write, fwd_instr, fault;
    logic [31:0] last_a = 32'h0;
    logic last_w = 1'b0, last_i = 1'b0;
    int error_cnt = 0, n_compared = 0, cycles = 0;
    // Expected port per access: 1 code, 2 system, 0 refused
    rag_row_t rows [12] = '{
        '{32'h0000_0000, 1'b0, 2'h1}, '{32'h1fff_fffc, 1'b1, 2'h1},
        '{32'h2000_0000, 1'b0, 2'h2}, '{32'h2000_0100, 1'b1, 2'h0},
        '{32'h2000_e000, 1'b0, 2'h0}, '{32'h2000_dffc, 1'b0, 2'h2},
        '{32'h4000_0010, 1'b0, 2'h0}, '{32'h4000_1010, 1'b1, 2'h2},
        '{32'h8000_0000, 1'b0, 2'h0}, '{32'h0010_0010, 1'b0, 2'h0},
        '{32'h6000_00f0, 1'b1, 2'h2}, '{32'h6000_0100, 1'b0, 2'h0}};
    int b2b [4] = '{3, 2, 0, 9};
    rag_core_model core (.clock(clock), .reset(reset), .go(go),
        .cmd_addr(cmd_addr), .cmd_write(cmd_write), .cmd_instr(cmd_instr),
        .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
        .req_instr(req_instr));
    rag_guard dut (.clock(clock), .reset(reset), .prot_enable(prot_enable),
        .rgn_enable(rgn_enable), .rgn_base(rgn_base),
        .rgn_size_exp(rgn_size_exp), .rgn_sub_disable(rgn_sub_disable),
        .rgn_read_only(rgn_read_only), .rgn_no_access(rgn_no_access),
        .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
        .req_instr(req_instr), .code_valid(code_valid),
        .sys_valid(sys_valid), .fwd_addr(fwd_addr), .fwd_write(fwd_write),
        .fwd_instr(fwd_instr), .fault(fault), .fault_addr(fault_addr));
    // Clock and hang guard
    initial begin
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic send(input rag_row_t r, input logic i);
        go <= 1'b1;
        cmd_addr <= r.a;
        cmd_write <= r.w;
        cmd_instr <= i;
    endtask : send
    // Refused accesses leave the forwarded fields untouched
    task automatic check(input rag_row_t r, input logic i);
        `CHK(code_valid, r.e[0])
        `CHK(sys_valid, r.e[1])
        `CHK(fault, r.e == 2'h0)
        if (r.e != 2'h0) begin
            last_a = r.a;
            last_w = r.w;
            last_i = i;
        end else `CHK(fault_addr, r.a)
        `CHK(fwd_addr, last_a)
        `CHK(fwd_write, last_w)
        `CHK(fwd_instr, last_i)
    endtask : check
    // After any reset every output reads zero
    task automatic check_idle();
        `CHK(code_valid, 1'b0)
        `CHK(sys_valid, 1'b0)
        `CHK(fault, 1'b0)
        `CHK(fault_addr, 32'h0)
        `CHK(fwd_addr, 32'h0)
        `CHK(fwd_write, 1'b0)
        `CHK(fwd_instr, 1'b0)
    endtask : check_idle
    initial begin
        // Region 0 code, 1 read-only with top eighth off, 2 and 4 no access
        rgn_base[1] = 32'h2000_0000;
        rgn_base[2] = 32'h4000_0000;
        rgn_base[3] = 32'h4000_1000;
        rgn_base[4] = 32'h0010_0000;
        rgn_base[5] = 32'h8000_0000;
        rgn_base[7] = 32'h6000_0000;
        rgn_size_exp = {6'h08, 6'h08, 6'h0c, 6'h08, 6'h0c, 6'h0c, 6'h10,
            6'h1d};
        rgn_sub_disable[1] = 8'h80;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        #1 check_idle();
        $display("reset test done");
        for (int k = 0; k < 12; k++) begin
            @(posedge clock) send(rows[k], k[0]);
            @(posedge clock) go <= 1'b0;
            @(posedge clock) #1 check(rows[k], k[0]);
        end
        $display("row test done");
        // Back to back: two allowed accesses between two faults
        for (int j = 0; j < 6; j++) begin
            @(posedge clock);
            if (j < 4) send(rows[b2b[j]], 1'b1);
            else go <= 1'b0;
            #1 if (j >= 2) check(rows[b2b[j - 2]], 1'b1);
        end
        $display("back to back test done");
        @(posedge clock) prot_enable <= 1'b0;
        send('{32'h8000_0000, 1'b1, 2'h2}, 1'b0);
        @(posedge clock) go <= 1'b0;
        @(posedge clock) #1 check('{32'h8000_0000, 1'b1, 2'h2}, 1'b0);
        // Pass-all reaches a no-access region on the code side
        @(posedge clock) send('{32'h0010_0010, 1'b1, 2'h1}, 1'b1);
        @(posedge clock) go <= 1'b0;
        @(posedge clock) #1 check('{32'h0010_0010, 1'b1, 2'h1}, 1'b1);
        $display("pass-all test done");
        // Mid-run reset clears held fields, then an access still passes
        @(posedge clock) reset <= 1'b1;
        @(posedge clock) reset <= 1'b0;
        #1 check_idle();
        @(posedge clock) send(rows[2], 1'b0);
        @(posedge clock) go <= 1'b0;
        @(posedge clock) #1 check(rows[2], 1'b0);
        $display("mid-run reset test done");
        finish_test();
    end
endmodule : test_region_access_guard
`default_nettype wire
